// ===== logic/nirq_irq_ctrl.sv
// Interrupt mask and status registers of an NFC reader, reached over APB.
// Assumes every event input is synchronous to clk, one cycle per pulse.
`include "nirq_consts.svh"

module nirq_irq_ctrl
#(
   parameter int ADDR_WIDTH   = 12,
   parameter int FIFO_WIDTH   = 10,
   parameter int GUARD_CYCLES = `NIRQ_GUARD_CYCLES
)
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_WIDTH-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output      logic [31:0]           prdata,
   output      logic                  pready,
   output      logic                  pslverr,
   input  wire logic                  oscStable,
   input  wire logic [FIFO_WIDTH-1:0] fifoCount,
   input  wire logic                  rxActive,
   input  wire logic                  txActive,
   input  wire logic                  rxStartEvt,
   input  wire logic                  rxEndEvt,
   input  wire logic                  txEndEvt,
   input  wire logic                  bitCollisionEvt,
   input  wire logic                  disturbanceDropEvt,
   input  wire logic                  cmdDoneEvt,
   input  wire logic                  noRespTimeoutEvt,
   input  wire logic                  gpTimeoutEvt,
   input  wire logic                  extFieldPresent,
   input  wire logic                  caCollisionEvt,
   input  wire logic                  caFieldOnEvt,
   input  wire logic                  targetMode,
   input  wire logic                  initiatorRateEvt,
   input  wire logic [7:0]            errWakePending,
   input  wire logic [7:0]            targetPending,
   output      logic                  oscEnable,
   output      logic [7:0]            errWakeMask,
   output      logic [7:0]            targetMask,
   output      logic                  irq
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   nirq_pkg::nirq_byte_type mainMask_reg;
   nirq_pkg::nirq_byte_type timerMask_reg;
   nirq_pkg::nirq_byte_type errMask_reg;
   nirq_pkg::nirq_byte_type targetMask_reg;
   nirq_pkg::nirq_byte_type mainStat_reg;
   nirq_pkg::nirq_byte_type mainStat_next;
   nirq_pkg::nirq_byte_type timerStat_reg;
   nirq_pkg::nirq_byte_type timerStat_next;
   nirq_pkg::nirq_byte_type mainSet;
   nirq_pkg::nirq_byte_type timerSet;
   nirq_pkg::nirq_byte_type mainClr;
   nirq_pkg::nirq_byte_type timerClr;
   nirq_pkg::nirq_guard_type guardState_reg;
   nirq_pkg::nirq_guard_type guardState_next;
   logic [31:0]             guardCount_reg;
   logic [31:0]             guardCount_next;
   logic                    ctrlOsc_reg;
   logic                    oscSeen_reg;
   logic                    fifoHit_reg;
   logic                    field_reg;
   logic                    guardDone;
   logic                    fifoHit;
   logic                    oscGood;
   logic [31:0]             readWord;
   logic [31:0]             prdata_reg;
   logic                    pready_reg;
   logic                    pslverr_reg;
   logic                    irq_reg;
   logic                    capture;
   logic                    doWrite;
   logic                    doRead;
   logic                    lowByte;
   logic                    mapped;
   logic [7:0]              index;
   logic [7:0]              wByte;

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   // The access completes one cycle after the access phase opens, so the
   // decode and the clear-on-read act at the edge that loads read data.
   assign capture = psel && penable && !pready_reg;
   assign index   = paddr[9:2];
   assign wByte   = pwdata[7:0];
   assign lowByte = pstrb[0];
   assign doWrite = capture && pwrite && mapped;
   assign doRead  = capture && !pwrite && mapped;

   always_comb
   begin
      mapped   = 1'b1;
      readWord = `NIRQ_ZERO_WORD;
      unique case (index)
         `NIRQ_IDX_MAIN_MASK:   readWord[7:0] = mainMask_reg;
         `NIRQ_IDX_TIMER_MASK:  readWord[7:0] = timerMask_reg;
         `NIRQ_IDX_ERR_MASK:    readWord[7:0] = errMask_reg;
         `NIRQ_IDX_TARGET_MASK: readWord[7:0] = targetMask_reg;
         `NIRQ_IDX_MAIN_STAT:   readWord[7:0] = mainStat_reg;
         `NIRQ_IDX_TIMER_STAT:  readWord[7:0] = timerStat_reg;
         `NIRQ_IDX_CONTROL:     readWord[`NIRQ_CTRL_OSC_EN] = ctrlOsc_reg;
         default:               mapped = 1'b0;
      endcase
   end

   // ****************************************************************
   // Bus answer
   // ****************************************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= `NIRQ_ZERO_WORD;
      end
      else
      begin
         pready_reg  <= capture;
         pslverr_reg <= capture && !mapped;
         if (capture && !pwrite)
         begin
            prdata_reg <= readWord;
         end
      end
   end

   // ****************************************************************
   // Mask and control registers
   // ****************************************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mainMask_reg   <= `NIRQ_MASK_RESET;
         timerMask_reg  <= `NIRQ_MASK_RESET;
         errMask_reg    <= `NIRQ_MASK_RESET;
         targetMask_reg <= `NIRQ_MASK_RESET;
         ctrlOsc_reg    <= 1'b0;
      end
      else if (doWrite && lowByte)
      begin
         unique case (index)
            `NIRQ_IDX_MAIN_MASK:
               mainMask_reg <= wByte & `NIRQ_MAIN_USED;
            `NIRQ_IDX_TIMER_MASK:
               timerMask_reg <= wByte & `NIRQ_TIMER_USED;
            `NIRQ_IDX_ERR_MASK:
               errMask_reg <= wByte & `NIRQ_ERR_USED;
            `NIRQ_IDX_TARGET_MASK:
               targetMask_reg <= wByte & `NIRQ_TARGET_USED;
            `NIRQ_IDX_CONTROL:
               ctrlOsc_reg <= wByte[`NIRQ_CTRL_OSC_EN];
            default:
               ctrlOsc_reg <= ctrlOsc_reg;
         endcase
      end
   end

   // ****************************************************************
   // Event edge detection
   // ****************************************************************
   // Level conditions are turned into one flag per rising edge (the field also per
   // falling edge), so a FIFO that stays above its mark does not refill the flag after every read.
   assign oscGood = ctrlOsc_reg && oscStable;
   assign fifoHit = (rxActive && (fifoCount > `NIRQ_FIFO_RX_HIGH)) ||
                    (txActive && (fifoCount < `NIRQ_FIFO_TX_LOW));

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         oscSeen_reg <= 1'b0;
         fifoHit_reg <= 1'b0;
         field_reg   <= 1'b0;
      end
      else
      begin
         oscSeen_reg <= oscGood;
         fifoHit_reg <= fifoHit;
         field_reg   <= extFieldPresent;
      end
   end

   // ****************************************************************
   // Guard timer after own field switch-on
   // ****************************************************************
   always_comb
   begin
      guardState_next = guardState_reg;
      guardCount_next = guardCount_reg;
      guardDone       = 1'b0;
      unique case (guardState_reg)
         nirq_pkg::NIRQ_GUARD_IDLE:
         begin
            if (caFieldOnEvt)
            begin
               guardState_next = nirq_pkg::NIRQ_GUARD_WAIT;
               guardCount_next = 32'(GUARD_CYCLES - 1);
            end
         end
         nirq_pkg::NIRQ_GUARD_WAIT:
         begin
            if (guardCount_reg == 32'd0)
            begin
               guardDone       = 1'b1;
               guardState_next = nirq_pkg::NIRQ_GUARD_IDLE;
            end
            else
            begin
               guardCount_next = guardCount_reg - 32'd1;
            end
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         guardState_reg <= nirq_pkg::NIRQ_GUARD_IDLE;
         guardCount_reg <= 32'd0;
      end
      else
      begin
         guardState_reg <= guardState_next;
         guardCount_reg <= guardCount_next;
      end
   end

   // ****************************************************************
   // Status set and clear terms
   // ****************************************************************
   always_comb
   begin
      mainSet = `NIRQ_STAT_RESET;
      mainSet[`NIRQ_MAIN_OSC]     = oscGood && !oscSeen_reg;
      mainSet[`NIRQ_MAIN_FIFO]    = fifoHit && !fifoHit_reg;
      mainSet[`NIRQ_MAIN_RXS]     = rxStartEvt;
      mainSet[`NIRQ_MAIN_RXE]     = rxEndEvt;
      mainSet[`NIRQ_MAIN_TXE]     = txEndEvt;
      mainSet[`NIRQ_MAIN_COL]     = bitCollisionEvt;
      mainSet[`NIRQ_MAIN_RESTART] = disturbanceDropEvt;
   end

   always_comb
   begin
      timerSet = `NIRQ_STAT_RESET;
      timerSet[`NIRQ_TMR_CMD]       = cmdDoneEvt;
      timerSet[`NIRQ_TMR_NORESP]    = noRespTimeoutEvt;
      timerSet[`NIRQ_TMR_GPT]       = gpTimeoutEvt;
      timerSet[`NIRQ_TMR_FIELD_ON]  = extFieldPresent && !field_reg;
      timerSet[`NIRQ_TMR_FIELD_OFF] = !extFieldPresent && field_reg;
      timerSet[`NIRQ_TMR_CA_COL]    = caCollisionEvt;
      timerSet[`NIRQ_TMR_GUARD]     = guardDone;
      timerSet[`NIRQ_TMR_RATE]      = targetMode && initiatorRateEvt;
   end

   // A read clears the whole register; writing ones clears chosen bits.
   always_comb
   begin
      mainClr  = `NIRQ_STAT_RESET;
      timerClr = `NIRQ_STAT_RESET;
      if (doRead && (index == `NIRQ_IDX_MAIN_STAT))
      begin
         mainClr = ~`NIRQ_STAT_RESET;
      end
      if (doRead && (index == `NIRQ_IDX_TIMER_STAT))
      begin
         timerClr = ~`NIRQ_STAT_RESET;
      end
      if (doWrite && lowByte && (index == `NIRQ_IDX_MAIN_STAT))
      begin
         mainClr = wByte;
      end
      if (doWrite && lowByte && (index == `NIRQ_IDX_TIMER_STAT))
      begin
         timerClr = wByte;
      end
   end

   // Set wins over clear so an event in the clearing cycle is kept.
   assign mainStat_next  = ((mainStat_reg & ~mainClr) | mainSet)
                           & `NIRQ_MAIN_USED;
   assign timerStat_next = (timerStat_reg & ~timerClr) | timerSet;

   // ****************************************************************
   // Status registers
   // ****************************************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mainStat_reg  <= `NIRQ_STAT_RESET;
         timerStat_reg <= `NIRQ_STAT_RESET;
      end
      else
      begin
         mainStat_reg  <= mainStat_next;
         timerStat_reg <= timerStat_next;
      end
   end

   // ****************************************************************
   // Interrupt line
   // ****************************************************************
   // Taken from the next status values so the line follows a clearing
   // read at the same edge, at the cost of one gate level before the flop.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         irq_reg <= 1'b0;
      end
      else
      begin
         irq_reg <= |(mainStat_next  & ~mainMask_reg)   ||
                    |(timerStat_next & ~timerMask_reg)  ||
                    |(errWakePending & ~errMask_reg
                      & `NIRQ_ERR_USED)                 ||
                    |(targetPending  & ~targetMask_reg
                      & `NIRQ_TARGET_USED);
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign prdata      = prdata_reg;
   assign pready      = pready_reg;
   assign pslverr     = pslverr_reg;
   assign irq         = irq_reg;
   assign oscEnable   = ctrlOsc_reg;
   assign errWakeMask = errMask_reg;
   assign targetMask  = targetMask_reg;

endmodule : nirq_irq_ctrl

// ===== logic/nirq_consts.svh
// Constants of the interrupt mask and status block: register indices,
// reset values, flag positions, FIFO thresholds and the guard time.
// Assumes a 100 MHz system clock; byte address is four times the index.
`ifndef NIRQ_CONSTS_SVH
`define NIRQ_CONSTS_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define NIRQ_IDX_MAIN_MASK    8'h16
`define NIRQ_IDX_TIMER_MASK   8'h17
`define NIRQ_IDX_ERR_MASK     8'h18
`define NIRQ_IDX_TARGET_MASK  8'h19
`define NIRQ_IDX_MAIN_STAT    8'h1a
`define NIRQ_IDX_TIMER_STAT   8'h1b
`define NIRQ_IDX_CONTROL      8'h20

// ****************************************************************
// Reset values and masks of implemented bits
// ****************************************************************
`define NIRQ_MASK_RESET       8'h00
`define NIRQ_STAT_RESET       8'h00
`define NIRQ_CTRL_RESET       8'h00
`define NIRQ_MAIN_USED        8'hfe
`define NIRQ_TIMER_USED       8'hff
`define NIRQ_ERR_USED         8'hfe
`define NIRQ_TARGET_USED      8'hfb
`define NIRQ_ZERO_WORD        32'h0000_0000

// ****************************************************************
// Flag positions
// ****************************************************************
`define NIRQ_MAIN_OSC         7
`define NIRQ_MAIN_FIFO        6
`define NIRQ_MAIN_RXS         5
`define NIRQ_MAIN_RXE         4
`define NIRQ_MAIN_TXE         3
`define NIRQ_MAIN_COL         2
`define NIRQ_MAIN_RESTART     1
`define NIRQ_TMR_CMD          7
`define NIRQ_TMR_NORESP       6
`define NIRQ_TMR_GPT          5
`define NIRQ_TMR_FIELD_ON     4
`define NIRQ_TMR_FIELD_OFF    3
`define NIRQ_TMR_CA_COL       2
`define NIRQ_TMR_GUARD        1
`define NIRQ_TMR_RATE         0
`define NIRQ_CTRL_OSC_EN      0

// ****************************************************************
// FIFO thresholds and guard time
// ****************************************************************
`define NIRQ_FIFO_RX_HIGH     10'd300
`define NIRQ_FIFO_TX_LOW      10'd200
`define NIRQ_CLK_PERIOD_NS    10
`define NIRQ_GUARD_TIME_NS    1000
`define NIRQ_GUARD_CYCLES \
   ((`NIRQ_GUARD_TIME_NS + `NIRQ_CLK_PERIOD_NS - 1) / `NIRQ_CLK_PERIOD_NS)

`endif

// ===== logic/nirq_pkg.sv
// Types shared by the interrupt mask and status block.
// Assumes nothing beyond a SystemVerilog compiler.
package nirq_pkg;

   typedef logic [7:0] nirq_byte_type;

   typedef enum logic [0:0]
   {
      NIRQ_GUARD_IDLE = 1'b0,
      NIRQ_GUARD_WAIT = 1'b1
   } nirq_guard_type;

endpackage : nirq_pkg

// ===== verif/nirq_host.sv
// APB master standing in for the host microcontroller.
// Assumes clk is the block's clock and the slave answers within 16 cycles.
module nirq_host
(
   input  wire logic        clk,
   output      logic        psel    = 1'b0,
   output      logic        penable = 1'b0,
   output      logic        pwrite  = 1'b0,
   output      logic [11:0] paddr   = 12'h000,
   output      logic [31:0] pwdata  = 32'h0000_0000,
   output      logic [3:0]  pstrb   = 4'h0,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ps;

   // The request is held whole until pready is sampled high at an edge.
   task automatic xfer
   (
      input  logic        wr,
      input  logic [7:0]  idx,
      input  logic [31:0] wd,
      input  logic [3:0]  strb,
      output logic [31:0] rd,
      output logic        err,
      output logic        hung
   );
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      pstrb  <= strb;
      @(posedge clk);
      penable <= 1'b1;
      hung = 1'b1;
      for (int i = 0; i < 16 && hung; i++)
      begin
         @(posedge clk);
         hung = (pready !== 1'b1);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : nirq_host

// ===== verif/nirq_irq_ctrl_chk.sv
// Assertions on the ports of the interrupt mask and status block.
// Assumes one clock and a synchronous active-high reset.
`include "nirq_consts.svh"
module nirq_irq_ctrl_chk
#(
   parameter int ADDR_WIDTH   = 12,
   parameter int GUARD_CYCLES = `NIRQ_GUARD_CYCLES
)
(
   input wire logic                  clk,
   input wire logic                  rst,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [3:0]            pstrb,
   input wire logic                  pready,
   input wire logic                  rxStartEvt,
   input wire logic                  rxEndEvt,
   input wire logic                  txEndEvt,
   input wire logic                  bitCollisionEvt,
   input wire logic                  disturbanceDropEvt,
   input wire logic                  cmdDoneEvt,
   input wire logic                  noRespTimeoutEvt,
   input wire logic                  gpTimeoutEvt,
   input wire logic                  extFieldPresent,
   input wire logic                  caFieldOnEvt,
   input wire logic                  targetMode,
   input wire logic                  initiatorRateEvt,
   input wire logic [7:0]            errWakeMask,
   input wire logic [7:0]            targetMask,
   input wire logic                  irq
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int GLO = GUARD_CYCLES;
   localparam int GHI = GUARD_CYCLES + 2;
   logic       wrTaken;
   logic [7:0] mainMaskReg;
   logic [7:0] timerMaskReg;
   logic [7:0] errMaskReg;
   logic [7:0] targetMaskReg;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   assign wrTaken = psel && penable && !pready && pwrite && pstrb[0];
   // Shadow masks; events are judged against what software last wrote.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mainMaskReg   <= 8'h00;
         timerMaskReg  <= 8'h00;
         errMaskReg    <= 8'h00;
         targetMaskReg <= 8'h00;
      end
      else if (wrTaken)
         case (paddr[9:2])
            `NIRQ_IDX_MAIN_MASK:   mainMaskReg   <= pwdata[7:0];
            `NIRQ_IDX_TIMER_MASK:  timerMaskReg  <= pwdata[7:0];
            `NIRQ_IDX_ERR_MASK:    errMaskReg    <= pwdata[7:0] & 8'hfe;
            `NIRQ_IDX_TARGET_MASK: targetMaskReg <= pwdata[7:0] & 8'hfb;
            default: ;
         endcase
   end
   // ****************
   // Properties
   // ****************
   property p_main_evt;
      |({rxStartEvt, rxEndEvt, txEndEvt, bitCollisionEvt, disturbanceDropEvt}
        & ~mainMaskReg[5:1]) |=> irq;
   endproperty
   a_main_evt: assert property (p_main_evt)
      else $error("unmasked main event gave no irq");
   property p_tmr_evt;
      |({cmdDoneEvt, noRespTimeoutEvt, gpTimeoutEvt} & ~timerMaskReg[7:5])
      |=> irq;
   endproperty
   a_tmr_evt: assert property (p_tmr_evt)
      else $error("unmasked timer event gave no irq");
   property p_field;
      $changed(extFieldPresent) && !(extFieldPresent ? timerMaskReg[4]
      : timerMaskReg[3]) |-> ##[1:2] irq;
   endproperty
   a_field: assert property (p_field)
      else $error("field change gave no irq");
   property p_guard;
      caFieldOnEvt && !timerMaskReg[1] |-> ##[GLO:GHI] irq;
   endproperty
   a_guard: assert property (p_guard)
      else $error("guard time flag missing");
   property p_rate;
      initiatorRateEvt && targetMode && !timerMaskReg[0] |=> irq;
   endproperty
   a_rate: assert property (p_rate)
      else $error("rate recognition gave no irq");
   property p_err_mask;
      wrTaken && paddr[9:2] == `NIRQ_IDX_ERR_MASK
      |=> ##[0:1] errWakeMask == errMaskReg;
   endproperty
   a_err_mask: assert property (p_err_mask)
      else $error("error mask copy wrong");
   property p_tgt_mask;
      wrTaken && paddr[9:2] == `NIRQ_IDX_TARGET_MASK
      |=> ##[0:1] targetMask == targetMaskReg;
   endproperty
   a_tgt_mask: assert property (p_tgt_mask)
      else $error("target mask copy wrong");
   property p_irq_fall;
      $fell(irq) |-> $past(psel && penable);
   endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("irq fell without a transfer");
   c_guard: cover property (caFieldOnEvt ##[GLO:GHI] irq);
   c_fall: cover property ($fell(irq));
   c_field: cover property ($fell(extFieldPresent) ##2 irq);
endmodule : nirq_irq_ctrl_chk

bind nirq_irq_ctrl nirq_irq_ctrl_chk
#(
   .ADDR_WIDTH   (ADDR_WIDTH),
   .GUARD_CYCLES (GUARD_CYCLES)
)
uChk
(
   .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
   .rxStartEvt, .rxEndEvt, .txEndEvt, .bitCollisionEvt, .disturbanceDropEvt,
   .cmdDoneEvt, .noRespTimeoutEvt, .gpTimeoutEvt, .extFieldPresent,
   .caFieldOnEvt, .targetMode, .initiatorRateEvt, .errWakeMask, .targetMask,
   .irq
);

// ===== verif/nirq_irq_ctrl_test.sv
// Self-checking bench of the interrupt mask and status block.
// Assumes the host model, checker and design are compiled before it.
module nirq_irq_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk             = 1'b0;
   logic        rst             = 1'b1;
   logic        oscStable       = 1'b0;
   logic        rxActive        = 1'b0;
   logic        txActive        = 1'b0;
   logic        extFieldPresent = 1'b0;
   logic [9:0]  fifoCount       = 10'h000;
   logic [11:0] ev              = 12'h000;
   logic [7:0]  errPend         = 8'h00;
   logic [7:0]  tgtPend         = 8'h00;
   logic [7:0]  errWakeMask, targetMask;
   logic        psel, penable, pwrite, pready, pslverr, oscEnable, irq;
   logic        perr, hung;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0]  pstrb;
   int          errCount        = 0;
   int          totalChecks     = 0;
   logic [7:0]  used [4]        = '{8'hfe, 8'hff, 8'hfe, 8'hfb};
   // Rows: event inputs, then expected main and timer status.
   logic [27:0] rows [8]        = '{28'h800_2000, 28'h600_1800,
      28'h180_0600, 28'h070_00e0, 28'h008_0004, 28'h004_0002,
      28'h003_0001, 28'h002_0000};

   nirq_host host
   (
      .clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr
   );
   // A short guard time keeps the run brief; expectations follow it.
   nirq_irq_ctrl #(.GUARD_CYCLES(3)) DUT
   (
      .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .oscStable, .fifoCount, .rxActive,
      .txActive, .rxStartEvt(ev[11]), .rxEndEvt(ev[10]), .txEndEvt(ev[9]),
      .bitCollisionEvt(ev[8]), .disturbanceDropEvt(ev[7]),
      .cmdDoneEvt(ev[6]), .noRespTimeoutEvt(ev[5]), .gpTimeoutEvt(ev[4]),
      .extFieldPresent, .caCollisionEvt(ev[3]), .caFieldOnEvt(ev[2]),
      .initiatorRateEvt(ev[1]), .targetMode(ev[0]),
      .errWakePending(errPend), .targetPending(tgtPend), .oscEnable,
      .errWakeMask, .targetMask, .irq
   );

   initial
      forever #5 clk = ~clk;

   // ****************
   // Tasks
   // ****************
   task automatic finalReport;
      if (errCount == 0 && totalChecks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finalReport

   task automatic check(input string n, input logic [31:0] e,
                        input logic [31:0] g);
      totalChecks++;
      if (g !== e)
      begin
         $display("unexpected %s expected %h seen %h", n, e, g);
         errCount++;
      end
   endtask : check

   task automatic bus(input logic w, input logic [7:0] idx,
                      input logic [31:0] d, input logic [3:0] s);
      host.xfer(w, idx, d, s, rdat, perr, hung);
      if (hung)
      begin
         check("pready", 32'h0000_0001, 32'h0000_0000);
         finalReport();
      end
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, {24'h00_0000, d}, 4'hf);
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 32'h0000_0000, 4'hf);
      check($sformatf("register %h", idx), {24'h00_0000, e}, rdat);
   endtask : rd

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic pulse(input logic [11:0] v);
      ev <= v;
      tick(1);
      ev <= 12'h000;
   endtask : pulse

   // ****************
   // Sequence
   // ****************
   initial
   begin
      tick(2);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++)
         rd(8'h16 + i[7:0], 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h16 + i[7:0], 8'hff);
         rd(8'h16 + i[7:0], used[i]);
      end
      pulse(12'hfff);
      tick(6);
      check("masked irq", 32'h0000_0000, 32'(irq));
      rd(8'h1a, 8'h3e);
      rd(8'h1b, 8'he7);
      for (int i = 0; i < 4; i++)
         wr(8'h16 + i[7:0], 8'h00);
      rd(8'h1b, 8'h00);
      foreach (rows[r])
      begin
         pulse(rows[r][27:16]);
         tick(6);
         check("irq", 32'(|rows[r][15:0]), 32'(irq));
         rd(8'h1a, rows[r][15:8]);
         rd(8'h1b, rows[r][7:0]);
         rd(8'h1a, 8'h00);
         rd(8'h1b, 8'h00);
         check("irq", 32'h0000_0000, 32'(irq));
      end
      // An event landing on the clearing edge must survive the read.
      pulse(12'h200);
      fork
         rd(8'h1a, 8'h08);
         begin
            tick(2);
            pulse(12'h400);
         end
      join
      rd(8'h1a, 8'h10);
      pulse(12'h600);
      wr(8'h1a, 8'h08);
      rd(8'h1a, 8'h10);
      extFieldPresent <= 1'b1;
      tick(4);
      rd(8'h1b, 8'h10);
      extFieldPresent <= 1'b0;
      tick(4);
      rd(8'h1b, 8'h08);
      oscStable <= 1'b1;
      tick(4);
      rd(8'h1a, 8'h00);
      wr(8'h20, 8'h01);
      check("oscEnable", 32'h0000_0001, 32'(oscEnable));
      tick(3);
      rd(8'h1a, 8'h80);
      rxActive <= 1'b1;
      fifoCount <= 10'h12c;
      tick(3);
      rd(8'h1a, 8'h00);
      fifoCount <= 10'h12d;
      tick(3);
      rd(8'h1a, 8'h40);
      rxActive <= 1'b0;
      txActive <= 1'b1;
      fifoCount <= 10'h0c8;
      tick(3);
      rd(8'h1a, 8'h00);
      fifoCount <= 10'h0c7;
      tick(3);
      rd(8'h1a, 8'h40);
      bus(1'b0, 8'h30, 32'h0000_0000, 4'hf);
      check("pslverr", 32'h0000_0001, 32'(perr));
      check("unmapped data", 32'h0000_0000, rdat);
      bus(1'b1, 8'h16, 32'h0000_00ff, 4'h0);
      rd(8'h16, 8'h00);
      errPend <= 8'h01;
      tick(3);
      check("err0 irq", 32'h0000_0000, 32'(irq));
      errPend <= 8'h80;
      tick(3);
      check("err irq", 32'h0000_0001, 32'(irq));
      wr(8'h18, 8'h80);
      tick(1);
      check("err mask irq", 32'h0000_0000, 32'(irq));
      check("errWakeMask", 32'h0000_0080, 32'(errWakeMask));
      errPend <= 8'h00;
      tgtPend <= 8'h04;
      tick(3);
      check("tgt2 irq", 32'h0000_0000, 32'(irq));
      tgtPend <= 8'h08;
      tick(3);
      check("tgt irq", 32'h0000_0001, 32'(irq));
      wr(8'h19, 8'h08);
      tick(1);
      check("tgt mask irq", 32'h0000_0000, 32'(irq));
      check("targetMask", 32'h0000_0008, 32'(targetMask));
      tgtPend <= 8'h00;
      rd(8'h20, 8'h01);
      // A mid-run reset must clear masks, flags, control and the line.
      txActive <= 1'b0;
      wr(8'h16, 8'hff);
      pulse(12'h800);
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      tick(1);
      check("rst irq", 32'h0000_0000, 32'(irq));
      check("rst oscEnable", 32'h0000_0000, 32'(oscEnable));
      for (int i = 0; i < 4; i++)
         rd(8'h16 + i[7:0], 8'h00);
      rd(8'h1a, 8'h00);
      rd(8'h20, 8'h00);
      finalReport();
   end
endmodule : nirq_irq_ctrl_test
